// [core/pav_regs.sv]
// How it works
// - Advertisement bit 5 is read-write, resets to one, advertises 10BASE-T half duplex.
// - Advertised abilities reach negotiation only after software writes the restart bit.
// - Advertisement bits 4:0 always read 0x01; writes there do nothing.
// - Selector codes decode as 802.3, 802.9, 802.5, 1394, rest reserved.
// - Register 0x05 holds link partner base page abilities, resets to zero.
// - Register 0x06 holds negotiation expansion status, resets to zero.
// - Vendor register sits at 0x10 and resets to 0x0140.
// - Repeater mode bit 15 refuses full duplex, carrier sense on receive only.
`timescale 1ns/1ps
`default_nettype none

module pav_regs (
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    // Register port
    input  wire logic [4:0]          i_addr,
    input  wire logic [15:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [15:0]         o_rdata,
    // Negotiation engine
    input  wire pav_pkg::pav_nego_t  i_nego,
    output logic                     o_autoneg_restart,
    output logic      [15:0]         o_adv_active,
    // PHY status and controls
    input  wire logic                i_rx_active,
    input  wire logic                i_tx_active,
    input  wire logic                i_full_duplex_req,
    input  wire logic                i_phy_irq_event,
    output logic                     o_full_duplex,
    output logic                     o_carrier_sense,
    output logic                     o_phy_irq,
    output logic                     o_repeater_mode_enable,
    output logic      [15:0]         o_vendor_cfg,
    output logic                     o_selector_ok
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [15:0]        adv_r;
    logic [15:0]        adv_active_r;
    logic [15:0]        lp_ability_r;
    logic [15:0]        expansion_r;
    logic [15:0]        vcfg_r;
    logic [15:0]        rdata_nxt;
    logic [15:0]        rdata_r;
    logic               restart_r;
    logic               nego_valid_r;
    logic               nego_valid_d_r;
    logic [15:0]        nego_lp_r;
    logic [15:0]        nego_exp_r;
    logic               rx_act_s;
    logic               tx_act_s;
    logic               irq_evt_s;
    logic               fd_req_s;
    logic               irq_active;
    logic               sel_8023;
    logic               sel_known;
    logic               sel_reserved;
    pav_pkg::pav_bus_t  bus;
    logic               wr_ctrl;
    logic               wr_adv;
    logic               wr_vcfg;
    logic [15:0]        adv_nxt;
    logic [15:0]        vcfg_nxt;
    logic [3:0]         pins_raw;
    logic [3:0]         pins_s;
    logic               fd_nxt;
    logic               cs_nxt;
    logic               irq_nxt;
    logic               cap_first;
    logic               cap_load;

    assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Strobes are one cycle long, so each enable lasts a single edge.
    always_comb begin
        wr_ctrl = bus.wr && (bus.addr == pav_pkg::ADDR_PHY_CTRL);
        wr_adv  = bus.wr && (bus.addr == pav_pkg::ADDR_LOCAL_ADV);
        wr_vcfg = bus.wr && (bus.addr == pav_pkg::ADDR_VENDOR_CFG);
    end

    // ----------------------------------------------------------------
    // Masked write values
    // ----------------------------------------------------------------
    // Fixed bits come from the reset constants, so no write can reach
    // the selector or the reserved fields.
    always_comb begin
        adv_nxt  = (bus.wdata & pav_pkg::ADV_WRITE_MASK)
                 | (pav_pkg::ADV_RESET & ~pav_pkg::ADV_WRITE_MASK);
        vcfg_nxt = (bus.wdata & pav_pkg::VCFG_WRITE_MASK)
                 | (pav_pkg::VCFG_RESET & ~pav_pkg::VCFG_WRITE_MASK);
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // The pins are asynchronous levels from the PHY core, so nothing reads
    // them before the second flop of the synchroniser.
    assign pins_raw = {i_rx_active, i_tx_active, i_phy_irq_event, i_full_duplex_req};

    pav_sync2 #(
        .WIDTH (4)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_d     (pins_raw),
        .o_q     (pins_s)
    );

    assign rx_act_s  = pins_s[3];
    assign tx_act_s  = pins_s[2];
    assign irq_evt_s = pins_s[1];
    assign fd_req_s  = pins_s[0];

    // ----------------------------------------------------------------
    // Local advertisement
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adv_r <= pav_pkg::ADV_RESET;
        end else if (wr_adv) begin
            // Only writable bits move; selector and reserved bits stay fixed.
            adv_r <= adv_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Restart and the copy seen by negotiation
    // ----------------------------------------------------------------
    // The restart bit self-clears, so it shows as a one-cycle pulse.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_ctrl && bus.wdata[pav_pkg::CTRL_RESTART_BIT];
        end
    end

    // Edits stay private until a restart, so a half-written set is never sent.
    // The copy lags the write of the restart bit by two edges.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adv_active_r <= pav_pkg::ADV_RESET;
        end else if (restart_r) begin
            adv_active_r <= adv_r;
        end
    end

    assign o_autoneg_restart = restart_r;
    assign o_adv_active      = adv_active_r;

    // ----------------------------------------------------------------
    // Selector decode
    // ----------------------------------------------------------------
    // The field is fixed, so this flag only guards against a broken mask.
    pav_sel_decode u_sel (
        .i_sel       (adv_r[4:0]),
        .o_ieee_8023 (sel_8023),
        .o_known     (sel_known),
        .o_reserved  (sel_reserved)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_selector_ok <= 1'b0;
        end else begin
            o_selector_ok <= sel_8023 && sel_known && !sel_reserved;
        end
    end

    // ----------------------------------------------------------------
    // Link partner results
    // ----------------------------------------------------------------
    // Results come from another clock; the snapshot is taken only once
    // the valid level has been carried across by the two-stage synchroniser.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nego_lp_r  <= pav_pkg::ZERO16;
            nego_exp_r <= pav_pkg::ZERO16;
        end else if (cap_first) begin
            nego_lp_r  <= i_nego.lp_ability;
            nego_exp_r <= i_nego.expansion;
        end
    end

    pav_sync2 #(
        .WIDTH (1)
    ) u_sync_valid (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_d     (i_nego.valid),
        .o_q     (nego_valid_r)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nego_valid_d_r <= 1'b0;
        end else begin
            nego_valid_d_r <= nego_valid_r;
        end
    end

    // A fresh result is caught once on the rising valid level; a restart
    // in the same cycle blocks the load for that cycle only, so a page caught with it is still loaded on the next.
    assign cap_first = nego_valid_r && !nego_valid_d_r;
    assign cap_load  = nego_valid_d_r && !restart_r;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lp_ability_r <= pav_pkg::LP_ABILITY_RESET;
        end else if (cap_load) begin
            lp_ability_r <= nego_lp_r;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            expansion_r <= pav_pkg::AN_EXPAN_RESET;
        end else if (cap_load) begin
            expansion_r <= nego_exp_r;
        end
    end

    // ----------------------------------------------------------------
    // Vendor configuration
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vcfg_r <= pav_pkg::VCFG_RESET;
        end else if (wr_vcfg) begin
            // Bit 14 is kept as a plain read-write bit.
            vcfg_r <= vcfg_nxt;
        end
    end

    assign o_vendor_cfg           = vcfg_r;
    assign o_repeater_mode_enable = vcfg_r[pav_pkg::VCFG_REPEATER_BIT];

    // ----------------------------------------------------------------
    // Repeater behaviour
    // ----------------------------------------------------------------
    // In repeater mode our own transmit must not look like traffic on the
    // wire, so carrier follows receive alone.
    always_comb begin
        fd_nxt = fd_req_s && !vcfg_r[pav_pkg::VCFG_REPEATER_BIT];
        cs_nxt = rx_act_s || tx_act_s;
        if (vcfg_r[pav_pkg::VCFG_REPEATER_BIT]) begin
            cs_nxt = rx_act_s;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_full_duplex <= 1'b0;
        end else begin
            o_full_duplex <= fd_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_carrier_sense <= 1'b0;
        end else begin
            o_carrier_sense <= cs_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pin polarity
    // ----------------------------------------------------------------
    // The event is a level from the PHY core; only its sense changes here.
    assign irq_active = irq_evt_s;

    always_comb begin
        irq_nxt = !irq_active;
        if (vcfg_r[pav_pkg::VCFG_IRQ_POL_BIT]) begin
            irq_nxt = irq_active;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phy_irq <= 1'b1;
        end else begin
            o_phy_irq <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = pav_pkg::ZERO16;
        case (bus.addr)
            // The control register is write-only here and reads as zero.
            pav_pkg::ADDR_PHY_CTRL:   begin
                rdata_nxt = pav_pkg::ZERO16;
            end
            pav_pkg::ADDR_LOCAL_ADV:  begin
                rdata_nxt = adv_r;
            end
            pav_pkg::ADDR_LP_ABILITY: begin
                rdata_nxt = lp_ability_r;
            end
            pav_pkg::ADDR_AN_EXPAN:   begin
                rdata_nxt = expansion_r;
            end
            pav_pkg::ADDR_VENDOR_CFG: begin
                rdata_nxt = vcfg_r;
            end
            default: begin
                rdata_nxt = pav_pkg::ZERO16;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    // Clearing them between reads keeps stale data off the return bus.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= pav_pkg::ZERO16;
        end else if (bus.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= pav_pkg::ZERO16;
        end
    end

    assign o_rdata = rdata_r;

endmodule : pav_regs

`default_nettype wire

// [core/pav_sel_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module pav_sel_decode (
    // Selector in
    input  wire logic [4:0] i_sel,
    // Decoded class
    output logic            o_ieee_8023,
    output logic            o_known,
    output logic            o_reserved
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        o_ieee_8023 = 1'b0;
        o_known     = 1'b0;
        o_reserved  = 1'b0;
        case (i_sel)
            pav_pkg::SEL_IEEE_8023: begin
                o_ieee_8023 = 1'b1;
                o_known     = 1'b1;
            end
            pav_pkg::SEL_IEEE_8029,
            pav_pkg::SEL_IEEE_8025,
            pav_pkg::SEL_IEEE_1394: begin
                o_known = 1'b1;
            end
            default: begin
                o_reserved = 1'b1;
            end
        endcase
    end

endmodule : pav_sel_decode

`default_nettype wire

// [core/pav_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

module pav_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Data
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_r;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (WIDTH < 1) begin : g_width_check
        $error("pav_sync2 needs a width of at least one");
    end

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end

endmodule : pav_sync2

`default_nettype wire

// [pkg/pav_pkg.sv]
package pav_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0]  ADDR_PHY_CTRL   = 5'h00;
    localparam logic [4:0]  ADDR_LOCAL_ADV  = 5'h04;
    localparam logic [4:0]  ADDR_LP_ABILITY = 5'h05;
    localparam logic [4:0]  ADDR_AN_EXPAN   = 5'h06;
    localparam logic [4:0]  ADDR_VENDOR_CFG = 5'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          CTRL_RESTART_BIT   = 9;
    localparam int          ADV_10_HALF_BIT    = 5;
    localparam int          VCFG_REPEATER_BIT  = 15;
    localparam int          VCFG_IRQ_POL_BIT   = 14;

    // ----------------------------------------------------------------
    // Reset values and masks
    // ----------------------------------------------------------------
    localparam logic [15:0] ADV_RESET          = 16'h01E1;
    localparam logic [15:0] ADV_WRITE_MASK     = 16'h21E0;
    localparam logic [15:0] LP_ABILITY_RESET   = 16'h0000;
    localparam logic [15:0] AN_EXPAN_RESET     = 16'h0000;
    localparam logic [15:0] VCFG_RESET         = 16'h0140;
    localparam logic [15:0] VCFG_WRITE_MASK    = 16'hDC33;
    localparam logic [15:0] ZERO16             = 16'h0000;

    // ----------------------------------------------------------------
    // Selector codes
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SEL_RESERVED_0 = 5'h00,
        SEL_IEEE_8023  = 5'h01,
        SEL_IEEE_8029  = 5'h02,
        SEL_IEEE_8025  = 5'h03,
        SEL_IEEE_1394  = 5'h04
    } pav_sel_t;

    localparam logic [4:0]  SEL_RESERVED_LO    = 5'h05;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pav_bus_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] lp_ability;
        logic [15:0] expansion;
    } pav_nego_t;

endpackage : pav_pkg

// [tb/pav_nego_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pav_nego_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // Negotiation control and results
    input  wire logic              i_restart,
    input  wire logic [15:0]       i_lp,
    input  wire logic [15:0]       i_exp,
    output var pav_pkg::pav_nego_t o_nego
);
    int cnt_r;

    // ----------------------------------------------------------------
    // Link partner exchange
    // ----------------------------------------------------------------
    // Pages arrive only after a restart has run; the data lines show junk while not valid.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r  <= 0;
            o_nego <= '0;
        end else if (i_restart) begin
            cnt_r  <= DELAY;
            o_nego <= {1'b0, ~i_lp, ~i_exp};
        end else if (cnt_r == 1) begin
            cnt_r  <= 0;
            o_nego <= {1'b1, i_lp, i_exp};
        end else if (cnt_r != 0) begin
            cnt_r  <= cnt_r - 1;
        end
    end
endmodule : pav_nego_model

`default_nettype wire

// [tb/pav_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module pav_regs_checker (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Register port
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] o_rdata,
    // Status and controls
    input  wire logic        i_rx_active,
    input  wire logic        i_phy_irq_event,
    input  wire logic        o_autoneg_restart,
    input  wire logic [15:0] o_adv_active,
    input  wire logic        o_full_duplex,
    input  wire logic        o_carrier_sense,
    input  wire logic        o_phy_irq,
    input  wire logic        o_repeater_mode_enable,
    input  wire logic [15:0] o_vendor_cfg
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_SEL_READ: assert property (i_rd && i_addr == pav_pkg::ADDR_LOCAL_ADV |=> o_rdata[4:0] == 5'h01)
        else $error("selector field read wrong");
    AST_ADV_WRITE: assert property (i_wr && i_addr == pav_pkg::ADDR_LOCAL_ADV
        ##1 i_rd && i_addr == pav_pkg::ADDR_LOCAL_ADV |=> o_rdata == (($past(i_wdata, 2)
        & pav_pkg::ADV_WRITE_MASK) | (pav_pkg::ADV_RESET & ~pav_pkg::ADV_WRITE_MASK)))
        else $error("advertisement write not read back");
    AST_VCFG_FIXED: assert property ((o_vendor_cfg & ~pav_pkg::VCFG_WRITE_MASK)
        == (pav_pkg::VCFG_RESET & ~pav_pkg::VCFG_WRITE_MASK))
        else $error("vendor fixed bits changed");
    AST_RESTART: assert property (i_wr && i_addr == pav_pkg::ADDR_PHY_CTRL && i_wdata[9]
        |=> o_autoneg_restart)
        else $error("restart pulse missing");
    AST_ADV_HOLD: assert property (!o_autoneg_restart |=> $stable(o_adv_active))
        else $error("active advertisement changed without restart");
    AST_ADV_SEL: assert property (o_adv_active[4:0] == pav_pkg::SEL_IEEE_8023)
        else $error("active selector not 802.3");
    AST_FD_REPEATER: assert property (o_repeater_mode_enable |=> !o_full_duplex)
        else $error("full duplex in repeater mode");
    AST_CS_REPEATER: assert property ((o_repeater_mode_enable && !i_rx_active) [*4]
        |=> !o_carrier_sense)
        else $error("carrier sense without receive in repeater mode");
    AST_IRQ_POL: assert property (($stable(i_phy_irq_event) && $stable(o_vendor_cfg[14])) [*4]
        |=> o_phy_irq == ($past(i_phy_irq_event) ~^ $past(o_vendor_cfg[14])))
        else $error("interrupt polarity wrong");

    COV_RESTART: cover property (o_autoneg_restart);
    COV_REPEATER: cover property (o_repeater_mode_enable && i_rx_active);
    COV_IRQ_HIGH: cover property (o_vendor_cfg[14] && o_phy_irq);
endmodule : pav_regs_checker

`default_nettype wire

// [tb/pav_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none

module pav_regs_test;
    localparam logic [15:0] LP_VAL  = 16'h45E1;
    localparam logic [15:0] EXP_VAL = 16'h0003;

    logic               i_clock, i_rst_n, i_wr, i_rd, o_autoneg_restart;
    logic [4:0]         i_addr;
    logic [15:0]        i_wdata, o_rdata, o_adv_active, o_vendor_cfg;
    logic               i_rx_active, i_tx_active, i_full_duplex_req, i_phy_irq_event;
    logic               o_full_duplex, o_carrier_sense, o_phy_irq;
    logic               o_repeater_mode_enable, o_selector_ok;
    pav_pkg::pav_nego_t nego;
    int                 err_total, checks;
    logic [4:0]         ta [7] = '{5'h04, 5'h10, 5'h05, 5'h06, 5'h1F, 5'h04, 5'h10};
    logic [15:0]        td [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
    logic [15:0]        te [7] = '{16'h21E1, 16'hDD73, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0140};

    pav_regs u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_nego(nego),
        .o_autoneg_restart(o_autoneg_restart), .o_adv_active(o_adv_active),
        .i_rx_active(i_rx_active), .i_tx_active(i_tx_active),
        .i_full_duplex_req(i_full_duplex_req), .i_phy_irq_event(i_phy_irq_event),
        .o_full_duplex(o_full_duplex), .o_carrier_sense(o_carrier_sense), .o_phy_irq(o_phy_irq),
        .o_repeater_mode_enable(o_repeater_mode_enable), .o_vendor_cfg(o_vendor_cfg),
        .o_selector_ok(o_selector_ok));
    pav_nego_model u_nego (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_restart(o_autoneg_restart),
        .i_lp(LP_VAL), .i_exp(EXP_VAL), .o_nego(nego));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Strobes stay up until the next call replaces them, so back-to-back calls never clash.
    task automatic bus_cyc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
    endtask : bus_cyc

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        bus_cyc(1'b0, 1'b1, a, 16'h0000);
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk("rdata", exp, o_rdata);
    endtask : rd_chk

    // The status inputs pass a two-stage synchroniser, so results are looked at six cycles on.
    task automatic phy(input logic rx, input logic tx, input logic fd, input logic ev);
        bus_cyc(1'b0, 1'b0, 5'h00, 16'h0000);
        i_rx_active       <= rx;
        i_tx_active       <= tx;
        i_full_duplex_req <= fd;
        i_phy_irq_event   <= ev;
        repeat (6) @(posedge i_clock);
        #1;
    endtask : phy

    task automatic chk_phy(input logic [3:0] e);
        chk("phy_outs", {12'h000, e}, {12'h000, o_full_duplex, o_carrier_sense, o_phy_irq,
            o_repeater_mode_enable});
    endtask : chk_phy

    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    initial begin
        repeat (5000) @(posedge i_clock);
        err_total++;
        report_and_stop();
    end

    initial begin
        {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        {i_rx_active, i_tx_active, i_full_duplex_req, i_phy_irq_event} = 4'h0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd_chk(5'h00, 16'h0000);
        rd_chk(5'h04, 16'h01E1);
        rd_chk(5'h05, 16'h0000);
        rd_chk(5'h06, 16'h0000);
        rd_chk(5'h10, 16'h0140);
        for (int i = 0; i < 7; i++) begin
            bus_cyc(1'b1, 1'b0, ta[i], td[i]);
            rd_chk(ta[i], te[i]);
        end
        chk("adv_active", 16'h01E1, o_adv_active);
        bus_cyc(1'b1, 1'b0, 5'h00, 16'h0200);
        phy(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (10) @(posedge i_clock);
        chk("adv_active", 16'h0001, o_adv_active);
        chk("selector_ok", 16'h0001, {15'h0000, o_selector_ok});
        rd_chk(5'h05, LP_VAL);
        rd_chk(5'h06, EXP_VAL);
        bus_cyc(1'b1, 1'b0, 5'h05, 16'h0000);
        bus_cyc(1'b1, 1'b0, 5'h06, 16'h0000);
        rd_chk(5'h05, LP_VAL);
        rd_chk(5'h06, EXP_VAL);
        chk_phy(4'b1110);
        phy(1'b0, 1'b1, 1'b1, 1'b1);
        chk_phy(4'b1100);
        bus_cyc(1'b1, 1'b0, 5'h10, 16'h8000);
        phy(1'b0, 1'b1, 1'b1, 1'b1);
        chk_phy(4'b0001);
        phy(1'b1, 1'b1, 1'b1, 1'b1);
        chk_phy(4'b0101);
        bus_cyc(1'b1, 1'b0, 5'h10, 16'h4000);
        phy(1'b0, 1'b0, 1'b1, 1'b1);
        chk_phy(4'b1010);
        phy(1'b0, 1'b0, 1'b1, 1'b0);
        chk_phy(4'b1000);
        report_and_stop();
    end
endmodule : pav_regs_test

bind pav_regs pav_regs_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_active(i_rx_active),
    .i_phy_irq_event(i_phy_irq_event), .o_autoneg_restart(o_autoneg_restart),
    .o_adv_active(o_adv_active), .o_full_duplex(o_full_duplex),
    .o_carrier_sense(o_carrier_sense), .o_phy_irq(o_phy_irq),
    .o_repeater_mode_enable(o_repeater_mode_enable), .o_vendor_cfg(o_vendor_cfg));

`default_nettype wire
